// file: verilog/sfe_pkg.sv
// Constants and types shared by the floating-point post-exception unit.
package sfe_pkg;

	// ********************************************************
	// Operation codes
	// ********************************************************
	typedef enum logic [3:0] {
		packed_single_add = 4'h0,
		packed_single_subtract = 4'h1,
		packed_single_multiply = 4'h2,
		packed_single_divide = 4'h3,
		scalar_single_add = 4'h4,
		scalar_single_subtract = 4'h5,
		scalar_single_multiply = 4'h6,
		scalar_single_divide = 4'h7,
		packed_single_square_root = 4'h8,
		scalar_single_square_root = 4'h9,
		packed_int_to_single = 4'hA,
		scalar_int_to_single = 4'hB,
		packed_single_to_int_rounded = 4'hC,
		packed_single_to_int_truncated = 4'hD,
		scalar_single_to_int_rounded = 4'hE,
		scalar_single_to_int_truncated = 4'hF
	} sfe_op_e;

	// ********************************************************
	// Register map and fields
	// ********************************************************
	localparam logic [7:0] SFE_ADR_CTRL = 8'h00;
	localparam logic [7:0] SFE_ADR_STAT = 8'h04;
	localparam logic [7:0] SFE_ADR_MASK = 8'h08;
	localparam int SFE_CTL_RC = 0;
	localparam int SFE_CTL_OM = 2;
	localparam int SFE_CTL_UM = 3;
	localparam int SFE_CTL_PM = 4;
	localparam logic [4:0] SFE_CTRL_RST = 5'h1C;
	localparam int SFE_ST_OVF = 0;
	localparam int SFE_ST_UNF = 1;
	localparam int SFE_ST_PRE = 2;
	localparam int SFE_ST_TRAP = 3;
	localparam logic [3:0] SFE_STAT_RST = 4'h0;
	localparam logic [3:0] SFE_MASK_RST = 4'h0;

	// ********************************************************
	// Rounding modes and number format
	// ********************************************************
	localparam logic [1:0] SFE_RC_NEAR = 2'h0;
	localparam logic [1:0] SFE_RC_DOWN = 2'h1;
	localparam logic [1:0] SFE_RC_UP = 2'h2;
	localparam logic [1:0] SFE_RC_ZERO = 2'h3;
	localparam logic signed [9:0] SFE_EXP_MAX = 10'h07F;
	localparam logic signed [9:0] SFE_EXP_MIN = 10'h382;
	localparam logic signed [9:0] SFE_BIAS = 10'h07F;
	localparam logic signed [9:0] SFE_SCALE = 10'h0C0;
	localparam logic signed [9:0] SFE_SH_CAP = 10'h01B;
	localparam logic [7:0] SFE_EXP_BIG = 8'hFE;
	localparam logic [7:0] SFE_EXP_INF = 8'hFF;
	localparam logic [22:0] SFE_FRAC_ONES = 23'h7FFFFF;
	localparam logic [22:0] SFE_FRAC_ZERO = 23'h000000;

endpackage

// file: verilog/sfe_post_exception.sv
// Post-computation overflow, underflow and precision response unit.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps

module sfe_post_exception
	import sfe_pkg::*;
#(
	parameter int ADR_W = 8
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Unrounded result from the arithmetic stage
	input wire logic in_valid_i,
	input wire sfe_op_e in_op_i,
	input wire logic in_zero_i,
	input wire logic in_sign_i,
	input wire logic signed [9:0] in_exp_i,
	input wire logic [26:0] in_sig_i,
	input wire logic [31:0] in_int_i,
	input wire logic in_int_inexact_i,
	// Delivered result
	output logic out_valid_o,
	output logic [31:0] out_res_o,
	output logic [2:0] out_flags_o,
	output logic out_trap_o,
	// Interrupt
	output logic irq_o
);

	// ********************************************************
	// Registers and decode
	// ********************************************************
	logic [4:0] ctrl;
	logic [3:0] stat;
	logic [3:0] imask;
	logic [1:0] rc;
	logic om;
	logic um;
	logic pm;
	logic wr_go;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_mask;
	logic [3:0] ev;
	logic [31:0] next_rdata;

	assign rc = ctrl[SFE_CTL_RC +: 2];
	assign om = ctrl[SFE_CTL_OM];
	assign um = ctrl[SFE_CTL_UM];
	assign pm = ctrl[SFE_CTL_PM];
	assign sel_ctrl = (wb_adr_i[7:0] == SFE_ADR_CTRL);
	assign sel_stat = (wb_adr_i[7:0] == SFE_ADR_STAT);
	assign sel_mask = (wb_adr_i[7:0] == SFE_ADR_MASK);
	// A write lands on the edge that samples ack, as the master expects.
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

	// ********************************************************
	// Rounding helper
	// ********************************************************
	function automatic logic round_inc(
		input logic [1:0] m,
		input logic s,
		input logic l,
		input logic g,
		input logic t
	);
		case (m)
			SFE_RC_NEAR: round_inc = g & (t | l);
			SFE_RC_DOWN: round_inc = s & (g | t);
			SFE_RC_UP: round_inc = ~s & (g | t);
			default: round_inc = 1'b0;
		endcase
	endfunction

	// ********************************************************
	// Result datapath
	// ********************************************************
	logic is_arith;
	logic is_toint;
	logic g_u;
	logic t_u;
	logic inc_u;
	logic inx_u;
	logic [24:0] n_sum;
	logic signed [9:0] er;
	logic ovf;
	logic unf;
	logic [9:0] eb_norm;
	logic [9:0] eb_ovf;
	logic [9:0] eb_unf;
	logic signed [9:0] sh;
	logic [5:0] sh_c;
	logic [53:0] wide;
	logic [26:0] d_sig;
	logic d_lost;
	logic g_d;
	logic t_d;
	logic inc_d;
	logic inx_d;
	logic [24:0] d_sum;
	logic big;
	logic [31:0] next_res;
	logic [2:0] next_flags;
	logic next_trap;

	always_comb
	begin
		is_arith = (in_op_i <= scalar_single_divide);
		is_toint = (in_op_i >= packed_single_to_int_rounded);
		// Round at the destination precision with unbounded exponent.
		g_u = in_sig_i[2];
		t_u = |in_sig_i[1:0];
		inc_u = round_inc(rc, in_sign_i, in_sig_i[3], g_u, t_u);
		inx_u = g_u | t_u;
		n_sum = {1'b0, in_sig_i[26:3]} + {24'h000000, inc_u};
		er = in_exp_i + $signed({9'h000, n_sum[24]});
		// Range checks apply only to the four basic operations.
		ovf = is_arith & ~in_zero_i & (er > SFE_EXP_MAX);
		unf = is_arith & ~in_zero_i & (er < SFE_EXP_MIN);
		eb_norm = er + SFE_BIAS;
		eb_ovf = er - SFE_SCALE + SFE_BIAS;
		eb_unf = er + SFE_SCALE + SFE_BIAS;
		// Denormalise from the unrounded value so rounding happens once.
		sh = SFE_EXP_MIN - in_exp_i;
		if (sh > SFE_SH_CAP)
			sh_c = SFE_SH_CAP[5:0];
		else
			sh_c = sh[5:0];
		wide = {in_sig_i, 27'h0000000} >> sh_c;
		d_sig = wide[53:27];
		d_lost = |wide[26:0];
		g_d = d_sig[2];
		t_d = (|d_sig[1:0]) | d_lost;
		inc_d = round_inc(rc, in_sign_i, d_sig[3], g_d, t_d);
		inx_d = g_d | t_d;
		d_sum = {1'b0, d_sig[26:3]} + {24'h000000, inc_d};
		if (in_sign_i)
			big = (rc == SFE_RC_UP) || (rc == SFE_RC_ZERO);
		else
			big = (rc == SFE_RC_DOWN) || (rc == SFE_RC_ZERO);
		next_res = {in_sign_i, eb_norm[7:0], n_sum[22:0]};
		next_flags = 3'h0;
		if (is_toint)
		begin
			next_res = in_int_i;
			next_flags[SFE_ST_PRE] = in_int_inexact_i;
		end
		else if (in_zero_i)
			next_res = {in_sign_i, 8'h00, SFE_FRAC_ZERO};
		else if (ovf && om)
		begin
			// Masked overflow wins whatever the precision mask says.
			next_flags[SFE_ST_OVF] = 1'b1;
			next_flags[SFE_ST_PRE] = 1'b1;
			if (big)
				next_res = {in_sign_i, SFE_EXP_BIG, SFE_FRAC_ONES};
			else
				next_res = {in_sign_i, SFE_EXP_INF, SFE_FRAC_ZERO};
		end
		else if (ovf)
		begin
			next_res = {in_sign_i, eb_ovf[7:0], n_sum[22:0]};
			next_flags[SFE_ST_OVF] = 1'b1;
			next_flags[SFE_ST_PRE] = inx_u;
		end
		else if (unf && um)
		begin
			// A carry into the hidden bit yields the smallest normal.
			next_res = {in_sign_i, 7'h00, d_sum[23:0]};
			next_flags[SFE_ST_UNF] = inx_d;
			next_flags[SFE_ST_PRE] = inx_d;
		end
		else if (unf)
		begin
			next_res = {in_sign_i, eb_unf[7:0], n_sum[22:0]};
			next_flags[SFE_ST_UNF] = 1'b1;
			next_flags[SFE_ST_PRE] = inx_u;
		end
		else
		begin
			// Square root and int-to-single also come this way.
			next_res = {in_sign_i, eb_norm[7:0], n_sum[22:0]};
			next_flags[SFE_ST_PRE] = inx_u;
		end
		// Any unmasked overflow, underflow or precision condition raises the trap.
		next_trap = (ovf & ~om) | (unf & ~um)
			| (next_flags[SFE_ST_PRE] & ~pm);
	end

	// ********************************************************
	// Output stage
	// ********************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_valid_o <= 1'b0;
			out_res_o <= 32'h00000000;
			out_flags_o <= 3'h0;
			out_trap_o <= 1'b0;
		end
		else
		begin
			out_valid_o <= in_valid_i;
			if (in_valid_i)
			begin
				out_res_o <= next_res;
				out_flags_o <= next_flags;
				out_trap_o <= next_trap;
			end
			else
			begin
				out_flags_o <= 3'h0;
				out_trap_o <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Control register
	// ********************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl <= SFE_CTRL_RST;
		else if (wr_go && sel_ctrl)
			ctrl <= wb_dat_i[4:0];
	end

	// ********************************************************
	// Sticky status and interrupt mask
	// ********************************************************
	assign ev = {out_valid_o & out_trap_o, out_valid_o ? out_flags_o : 3'h0};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stat <= SFE_STAT_RST;
		else if (wr_go && sel_stat)
			stat <= (stat & ~wb_dat_i[3:0]) | ev;
		else
			stat <= stat | ev;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			imask <= SFE_MASK_RST;
		else if (wr_go && sel_mask)
			imask <= wb_dat_i[3:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(stat & imask);
	end

	// ********************************************************
	// Bus answer
	// ********************************************************
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (sel_ctrl)
			next_rdata[4:0] = ctrl;
		else if (sel_stat)
			next_rdata[3:0] = stat;
		else if (sel_mask)
			next_rdata[3:0] = imask;
	end

	// Every access, mapped or not, is acknowledged after one cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o)
				wb_dat_o <= next_rdata;
		end
	end

endmodule

// file: dv/sfe_checker.sv
// Port-level assertions for the post-exception unit.
`timescale 1ns/100ps
module sfe_checker
	import sfe_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic wb_ack_o,
	input wire logic in_valid_i,
	input wire sfe_op_e in_op_i,
	input wire logic in_zero_i,
	input wire logic out_valid_o,
	input wire logic [31:0] out_res_o,
	input wire logic [2:0] out_flags_o,
	input wire logic out_trap_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// A set flag without a trap can only come from a masked condition.
	wire mo = out_valid_o && out_flags_o[0] && !out_trap_o;
	wire mu = out_valid_o && out_flags_o[1] && !out_trap_o;
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_valid_lat: assert property (1 |=> out_valid_o == $past(in_valid_i))
		else $error("result latency wrong");
	a_ovf_prec: assert property (mo |-> out_flags_o[2])
		else $error("masked overflow lacks precision flag");
	a_max_fin: assert property (
		mo |-> out_res_o[30:0] inside {31'h7F7FFFFF, 31'h7F800000})
		else $error("masked overflow result wrong");
	a_unf_prec: assert property (mu |-> out_flags_o[2])
		else $error("masked underflow lacks precision flag");
	a_unf_res: assert property (mu |-> out_res_o[30:24] == 7'h00)
		else $error("masked underflow result too large");
	a_arith_only: assert property (
		out_valid_o && $past(in_op_i[3]) |-> out_flags_o[1:0] == 2'h0)
		else $error("range flag on non-arithmetic op");
	a_zero_quiet: assert property (
		$past(in_valid_i && in_zero_i && !in_op_i[3]) |->
		out_flags_o == 3'h0 && out_res_o[30:0] == 31'h0)
		else $error("zero result not quiet");
	cover property (mo);
	cover property (out_valid_o && out_flags_o[1] && out_trap_o);
	cover property (out_valid_o && out_flags_o == 3'h4 && out_trap_o);
endmodule

// file: dv/testbench.sv
// Self-checking bench for the post-exception unit.
`timescale 1ns/100ps
module testbench;
	import sfe_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0, wb_ack_o, in_valid_i = 1'h0, in_zero_i = 1'h0;
	logic in_sign_i = 1'h0, in_int_inexact_i = 1'h0;
	logic out_valid_o, out_trap_o, irq_o;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = '0, wb_dat_o, in_int_i = '0, out_res_o, d;
	sfe_op_e in_op_i = packed_single_add;
	logic signed [9:0] in_exp_i = '0;
	logic [26:0] in_sig_i = '0;
	logic [2:0] out_flags_o;
	logic [35:0] q[$], y, y_chk;
	logic [3:0] st_m = '0;
	int seed = 59, n_mismatch = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	sfe_post_exception u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_valid_i,
		.in_op_i, .in_zero_i, .in_sign_i, .in_exp_i, .in_sig_i, .in_int_i,
		.in_int_inexact_i, .out_valid_o, .out_res_o, .out_flags_o,
		.out_trap_o, .irq_o);
	// ****
	// Reference model
	// ****
	function automatic logic [25:0] rnd(logic [23:0] k, logic g, logic t,
		logic s, logic [1:0] rc);
		logic x, u;
		x = g | t;
		case (rc)
			2'h0: u = g & (t | k[0]);
			2'h1: u = x & s;
			2'h2: u = x & !s;
			default: u = 1'h0;
		endcase
		return {x, {1'h0, k} + 25'(u)};
	endfunction
	function automatic logic [35:0] model(logic [3:0] op, logic z, logic s,
		int e, logic [26:0] sg, logic [31:0] iv, logic ix, logic [4:0] c);
		logic [25:0] r;
		logic [58:0] w;
		logic [2:0] f;
		logic [31:0] v;
		logic o, un;
		int er;
		if (op >= 4'hC)
			return {ix & !c[4], ix, 2'h0, iv};
		if (z)
			return {4'h0, s, 31'h0};
		r = rnd(sg[26:3], sg[2], |sg[1:0], s, c[1:0]);
		er = e + int'(r[24]);
		v = {s, 8'(er + 127), r[22:0]};
		f = {r[25], 2'h0};
		o = op < 4'h8 && er > 127;
		un = op < 4'h8 && er < -126;
		if (o && c[2])
		begin
			f = 3'h5;
			v[30:0] = c[1:0] == 2'h3 || c[1:0] == (s ? 2'h2 : 2'h1) ?
				31'h7F7FFFFF : 31'h7F800000;
		end
		else if (o)
			{f[0], v[30:23]} = {1'h1, 8'(er - 65)};
		else if (un && c[3])
		begin
			// Denormalise from the unrounded value so rounding happens once.
			w = {sg, 32'h0} >> (-126 - e);
			r = rnd(w[58:35], w[34], |w[33:0], s, c[1:0]);
			v = {s, 7'h0, r[23:0]};
			f = {r[25], r[25], 1'h0};
		end
		else if (un)
			{f[1], v[30:23]} = {1'h1, 8'(er + 319)};
		return {(o & !c[2]) | (un & !c[3]) | (f[2] & !c[4]), f, v};
	endfunction
	// ****
	// Bus and checking
	// ****
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] v, output logic [31:0] r,
		input logic [3:0] s = 4'hF);
		int i;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_sel_i <= s;
		wb_adr_i <= a;
		wb_dat_i <= v;
		for (i = 0; i < 50 && wb_ack_o !== 1'h1; i++)
			@(posedge clk_i);
		if (i == 50)
			tally_and_finish(1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task automatic tally_and_finish(input int bad);
		n_mismatch += bad;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i)
		if (out_valid_o === 1'h1)
		begin
			y_chk = q.size() > 0 ? q.pop_front() : '1;
			chk({out_trap_o, out_flags_o, out_res_o}, y_chk);
		end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		tally_and_finish(1);
	end
	initial
	begin
		logic [26:0] sg;
		logic [31:0] iv;
		logic [3:0] op;
		logic z;
		int e;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 4; i++)
		begin
			wb(1'h0, 8'(i * 4), '0, d);
			chk(36'(d), i > 0 ? '0 : 36'(SFE_CTRL_RST));
		end
		for (int k = 0; k < 32; k++)
		begin
			wb(1'h1, SFE_ADR_CTRL, 32'(k), d);
			wb(1'h0, SFE_ADR_CTRL, '0, d);
			chk(36'(d), 36'(k));
			repeat (10)
			begin
				@(posedge clk_i);
				op = 4'($random(seed));
				e = $random(seed) % 160;
				e = op[3] ? e / 2 : e;
				sg = {1'h1, 26'($random(seed))};
				sg[2:0] = sg[5:4] == 2'h0 ? 3'h0 : sg[2:0];
				z = op < 4'hC && sg[9:6] == 4'h0;
				iv = $random(seed);
				{in_valid_i, in_zero_i, in_sign_i} <= {1'h1, z, sg[11]};
				{in_int_i, in_int_inexact_i} <= {iv, sg[10]};
				{in_sig_i, in_exp_i} <= {sg, 10'(e)};
				in_op_i <= sfe_op_e'(op);
				y = model(op, z, sg[11], e, sg, iv, sg[10], 5'(k));
				q.push_back(y);
				st_m |= y[35:32];
			end
			@(posedge clk_i);
			in_valid_i <= 1'h0;
		end
		// A write without the low byte lane must leave the control alone.
		wb(1'h1, SFE_ADR_CTRL, 32'h0, d, 4'hE);
		wb(1'h0, SFE_ADR_CTRL, '0, d);
		chk(36'(d), 36'h1F);
		repeat (4) @(posedge clk_i);
		wb(1'h0, SFE_ADR_STAT, '0, d);
		chk(36'(d), 36'(st_m));
		chk(36'(irq_o), '0);
		wb(1'h1, SFE_ADR_MASK, 32'hF, d);
		repeat (3) @(posedge clk_i);
		chk(36'(irq_o), 36'(|st_m));
		wb(1'h1, SFE_ADR_STAT, 32'h5, d);
		wb(1'h0, SFE_ADR_STAT, '0, d);
		chk(36'(d), 36'(st_m & 4'hA));
		wb(1'h1, SFE_ADR_STAT, 32'hF, d);
		repeat (3) @(posedge clk_i);
		chk(36'(irq_o), '0);
		tally_and_finish(0);
	end
endmodule
bind sfe_post_exception sfe_checker u_chk (.clk_i, .rst_i, .wb_ack_o,
	.in_valid_i, .in_op_i, .in_zero_i, .out_valid_o, .out_res_o,
	.out_flags_o, .out_trap_o);
